// [inc/rcp_pkg.sv]
// Package: register layout and constants for the clock configuration register block
package rcp_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register offsets (word index on the plain register port)
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_VAL_HIGH = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_VAL_LOW = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
	// Field positions in the configuration register
	localparam int BIT_ON = 15;
	localparam int BIT_UNUSED = 14;
	localparam int BIT_UNLOCK = 13;
	localparam int BIT_RIPPLE = 12;
	localparam int BIT_HALF = 11;
	localparam int BIT_PIN_OE = 10;
	localparam int PTR_HI = 9;
	localparam int PTR_LO = 8;
	// Pointer codes
	localparam logic [1:0] PTR_0 = 2'h0;
	localparam logic [1:0] PTR_1 = 2'h1;
	localparam logic [1:0] PTR_2 = 2'h2;
	localparam logic [1:0] PTR_3 = 2'h3;
	// Reset values and the last seconds count
	localparam logic [1:0] PTR_RST = 2'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] CAL_RST = 8'h00;
	localparam logic [7:0] SEC_LAST = 8'h3B;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	// Time field indices inside the field store
	localparam int FLD_NUM = 8;
	localparam logic [2:0] FLD_SEC = 3'h0;
	localparam logic [2:0] FLD_MIN = 3'h1;
	localparam logic [2:0] FLD_HOUR = 3'h2;
	localparam logic [2:0] FLD_WDAY = 3'h3;
	localparam logic [2:0] FLD_DAY = 3'h4;
	localparam logic [2:0] FLD_MONTH = 3'h5;
	localparam logic [2:0] FLD_YEAR = 3'h6;
	localparam logic [2:0] FLD_RSVD = 3'h7;
	// Timing: ripple window ahead of a rollover, and one second period
	localparam int RIPPLE_NS = 100;
	localparam int CLK_NS = 5;
	localparam int RIPPLE_CYC = (RIPPLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SECOND_CYC = 200000000;
endpackage

// [logic/rcp_config.sv]
// Design: clock configuration register, value window pointer and simple seconds chain
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rcp_config #(
	parameter int SECOND_CYCLES = rcp_pkg::SECOND_CYC,
	parameter int RIPPLE_CYCLES = rcp_pkg::RIPPLE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [rcp_pkg::ADDR_W-1:0] addr,
	input wire logic [rcp_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [rcp_pkg::DATA_W-1:0] rdata,
	output logic clock_module_on,
	output logic clock_pin_output_on,
	output logic clock_pin_out,
	output logic rollover_ripple_flag,
	output logic second_half_flag
);
	// ****************************************
	// Field mapping
	// ****************************************
	function automatic logic [2:0] hi_field(input logic [1:0] p);
		logic [2:0] f;
		f = rcp_pkg::FLD_RSVD;
		case (p)
			rcp_pkg::PTR_0: f = rcp_pkg::FLD_MIN;
			rcp_pkg::PTR_1: f = rcp_pkg::FLD_WDAY;
			rcp_pkg::PTR_2: f = rcp_pkg::FLD_MONTH;
			default: f = rcp_pkg::FLD_RSVD;
		endcase
		return f;
	endfunction

	function automatic logic [2:0] lo_field(input logic [1:0] p);
		logic [2:0] f;
		f = rcp_pkg::FLD_SEC;
		case (p)
			rcp_pkg::PTR_0: f = rcp_pkg::FLD_SEC;
			rcp_pkg::PTR_1: f = rcp_pkg::FLD_HOUR;
			rcp_pkg::PTR_2: f = rcp_pkg::FLD_DAY;
			default: f = rcp_pkg::FLD_YEAR;
		endcase
		return f;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic on_q, on_d;
	logic unlock_q, unlock_d;
	logic oe_q, oe_d;
	logic [1:0] ptr_q, ptr_d;
	logic [7:0] cal_q, cal_d;
	logic [7:0] fld_q [rcp_pkg::FLD_NUM];
	logic [7:0] fld_d [rcp_pkg::FLD_NUM];
	logic [31:0] tick_q, tick_d;
	logic [rcp_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic ripple;
	logic half;
	logic sec_wrap;
	logic acc_hi;

	// Counter stops when disabled, keeping the current phase
	assign sec_wrap = on_q && (tick_q == 32'(SECOND_CYCLES - 1));
	// Ripple window covers the cycles just before a seconds rollover
	assign ripple = on_q && (tick_q >= 32'(SECOND_CYCLES - RIPPLE_CYCLES));
	assign half = (tick_q >= 32'(SECOND_CYCLES / 2));
	assign acc_hi = (addr == rcp_pkg::OFS_VAL_HIGH) && (wr || rd);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		on_d = on_q;
		unlock_d = unlock_q;
		oe_d = oe_q;
		ptr_d = ptr_q;
		cal_d = cal_q;
		fld_d = fld_q;
		tick_d = tick_q;
		rdata_d = rcp_pkg::WORD_ZERO;
		if (on_q) begin
			tick_d = sec_wrap ? 32'h0 : tick_q + 32'h1;
		end
		// Only seconds roll here; the full calendar chain lives elsewhere
		if (sec_wrap) begin
			fld_d[rcp_pkg::FLD_SEC] = (fld_q[rcp_pkg::FLD_SEC] == rcp_pkg::SEC_LAST) ?
				rcp_pkg::BYTE_RST :
				fld_q[rcp_pkg::FLD_SEC] + 8'h01;
		end
		if (wr) begin
			if (addr == rcp_pkg::OFS_CONFIG) begin
				on_d = wdata[rcp_pkg::BIT_ON];
				unlock_d = wdata[rcp_pkg::BIT_UNLOCK];
				oe_d = wdata[rcp_pkg::BIT_PIN_OE];
				ptr_d = wdata[rcp_pkg::PTR_HI:rcp_pkg::PTR_LO];
				cal_d = wdata[7:0];
			end else if (addr == rcp_pkg::OFS_VAL_HIGH) begin
				if (unlock_q) begin
					fld_d[hi_field(ptr_q)] = wdata[15:8];
					fld_d[lo_field(ptr_q)] = wdata[7:0];
				end
			end else if (addr == rcp_pkg::OFS_VAL_LOW) begin
				if (unlock_q) begin
					fld_d[lo_field(ptr_q)] = wdata[7:0];
				end
			end
		end
		if (rd) begin
			if (addr == rcp_pkg::OFS_CONFIG) begin
				rdata_d[rcp_pkg::BIT_ON] = on_q;
				rdata_d[rcp_pkg::BIT_UNUSED] = 1'b0;
				rdata_d[rcp_pkg::BIT_UNLOCK] = unlock_q;
				rdata_d[rcp_pkg::BIT_RIPPLE] = ripple;
				rdata_d[rcp_pkg::BIT_HALF] = half;
				rdata_d[rcp_pkg::BIT_PIN_OE] = oe_q;
				rdata_d[rcp_pkg::PTR_HI:rcp_pkg::PTR_LO] = ptr_q;
				rdata_d[7:0] = cal_q;
			end else if (addr == rcp_pkg::OFS_VAL_HIGH || addr == rcp_pkg::OFS_VAL_LOW) begin
				// Reserved field reads zero
				rdata_d[15:8] = (ptr_q == rcp_pkg::PTR_3) ? rcp_pkg::BYTE_RST :
					fld_q[hi_field(ptr_q)];
				rdata_d[7:0] = fld_q[lo_field(ptr_q)];
			end
		end
		// A config write in the same cycle wins over the decrement
		if (acc_hi && !(wr && addr == rcp_pkg::OFS_CONFIG) && ptr_q != rcp_pkg::PTR_0) begin
			ptr_d = ptr_q - 2'h1;
		end
		fld_d[rcp_pkg::FLD_RSVD] = rcp_pkg::BYTE_RST;
	end

	// ****************************************
	// Registers (nrst is the power-on reset only)
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			on_q <= 1'b0;
			unlock_q <= 1'b0;
			oe_q <= 1'b0;
			ptr_q <= rcp_pkg::PTR_RST;
			cal_q <= rcp_pkg::CAL_RST;
			tick_q <= 32'h0;
			rdata_q <= rcp_pkg::WORD_ZERO;
			for (int i = 0; i < rcp_pkg::FLD_NUM; i++) begin
				fld_q[i] <= rcp_pkg::BYTE_RST;
			end
		end else begin
			on_q <= on_d;
			unlock_q <= unlock_d;
			oe_q <= oe_d;
			ptr_q <= ptr_d;
			cal_q <= cal_d;
			tick_q <= tick_d;
			rdata_q <= rdata_d;
			fld_q <= fld_d;
		end
	end

	assign rdata = rdata_q;
	assign clock_module_on = on_q;
	assign clock_pin_output_on = oe_q;
	// Pin carries the seconds clock only while enabled
	assign clock_pin_out = oe_q && on_q && half;
	assign rollover_ripple_flag = ripple;
	assign second_half_flag = half;
endmodule

// [bench/rcp_config_props.sv]
// Checker: port properties of the clock configuration register
`timescale 1ns/1ps
module rcp_config_props #(
	parameter int SECOND_CYCLES = 100,
	parameter int RIPPLE_CYCLES = 4
) (
	input logic clk,
	input logic nrst,
	input logic [3:0] addr,
	input logic [15:0] wdata,
	input logic wr,
	input logic rd,
	input logic [15:0] rdata,
	input logic clock_module_on,
	input logic clock_pin_output_on,
	input logic clock_pin_out,
	input logic rollover_ripple_flag,
	input logic second_half_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire cfg_wr = wr && addr == 4'h0;
	wire cfg_rd = rd && addr == 4'h0;
	// Run lengths of the two level flags, counted in running cycles
	int rip_run, half_run;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rip_run <= 0;
			half_run <= 0;
		end else begin
			rip_run <= rollover_ripple_flag ? rip_run + 1 : 0;
			half_run <= !second_half_flag ? 0 : half_run + int'(clock_module_on);
		end
	end
	ripple_len_a: assert property (rip_run <= RIPPLE_CYCLES)
		else $error("ripple flag held too long");
	half_len_a: assert property (half_run <= SECOND_CYCLES / 2)
		else $error("second half flag held too long");
	on_follows_a: assert property (cfg_wr |=> clock_module_on == $past(wdata[15]))
		else $error("enable bit not taken");
	oe_follows_a: assert property (cfg_wr |=> clock_pin_output_on == $past(wdata[10]))
		else $error("output enable not taken");
	pin_gate_a: assert property (clock_pin_out |-> clock_pin_output_on && clock_module_on)
		else $error("clock pin driven while gated");
	ripple_off_a: assert property (!clock_module_on |-> !rollover_ripple_flag)
		else $error("ripple flag while stopped");
	ripple_late_a: assert property (rollover_ripple_flag |-> second_half_flag)
		else $error("ripple flag in first half");
	gap_zero_a: assert property (cfg_rd |=> !rdata[14])
		else $error("unused bit reads one");
	half_read_a: assert property (cfg_rd |=> rdata[11] == $past(second_half_flag))
		else $error("half flag read mismatch");
	ripple_read_a: assert property (cfg_rd |=> rdata[12] == $past(rollover_ripple_flag))
		else $error("ripple flag read mismatch");
	cover property ($rose(rollover_ripple_flag));
	cover property ($rose(clock_pin_out));
	cover property (rd && addr == 4'h1);
endmodule

// [bench/tb_top.sv]
// Testbench: random and corner stimulus for the clock configuration register
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, nrst = 0, wr = 0, rd = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, got, r, rdata, e;
	logic [15:0] fld [4];
	logic on, oe, pin, rip, half;
	int n_errors = 0, n_tests = 0, cyc = 0, k;
	int c [3];
	always #2.5 clk = ~clk;
	// Short second keeps the run small
	rcp_config #(.SECOND_CYCLES(100), .RIPPLE_CYCLES(4)) i_rcp_config (.clk(clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clock_module_on(on),
		.clock_pin_output_on(oe), .clock_pin_out(pin), .rollover_ripple_flag(rip),
		.second_half_flag(half));
	function automatic logic [15:0] fexp(int p, logic [15:0] f);
		return (p == 3) ? {8'h00, f[7:0]} : f;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic [3:0] a, input logic w, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic cnt();
		c = '{0, 0, 0};
		repeat (200) begin
			@(posedge clk);
			#1 c[0] += half;
			c[1] += rip;
			c[2] += pin;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(32'hCEACDFE5));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		acc(4'h0, 0, 0); chk(got, 16'h0000);
		for (k = 0; k < 24; k++) begin
			r = (k == 0) ? 16'hFFFF : 16'($urandom);
			acc(4'h0, 1, r);
			acc(4'h0, 0, 0); chk(got & 16'hE7FF, r & 16'hA7FF);
		end
		$display("test config done");
		// Mid-run power-on reset puts the second counter back to phase zero
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		acc(4'h0, 0, 0); chk(got, 16'h0000);
		// Stopped module: unlocked writes land per pointer, a locked write is ignored, each high value access steps the pointer down, stopping at zero
		for (k = 3; k >= 0; k--) begin
			fld[k] = 16'($urandom);
			acc(4'h0, 1, 16'h2000 | 16'(k << 8));
			acc(4'h1, 1, fld[k]);
		end
		acc(4'h0, 1, 16'h0100);
		acc(4'h1, 1, ~fld[1]);
		acc(4'h1, 0, 0);
		acc(4'h0, 0, 0); chk(got, 16'h0000);
		for (k = 0; k < 4; k++) begin
			acc(4'h0, 1, 16'(k << 8));
			acc(4'h1, 0, 0); chk(got, fexp(k, fld[k]));
			acc(4'h0, 0, 0); chk(got, 16'(k ? k - 1 : 0) << 8);
		end
		$display("test fields done");
		acc(4'h0, 1, 16'h8400);
		cnt(); chk({8'(c[0]), 8'(c[1])}, 16'h6408); chk(16'(c[2]), 16'h0064);
		acc(4'h0, 1, 16'h8000);
		cnt(); chk({8'(c[0]), 8'(c[2])}, 16'h6400);
		acc(4'h0, 1, 16'h0000);
		cnt(); chk({8'(c[1]), 8'(c[2])}, 16'h0000);
		$display("test running done");
		// Software double read: only a matching pair is trusted
		acc(4'h0, 1, 16'h2000);
		acc(4'h1, 1, 16'h1234);
		acc(4'h0, 1, 16'h8000);
		e = 16'h1234;
		repeat (60) begin
			acc(4'h1, 0, 0);
			r = got;
			acc(4'h1, 0, 0);
			if (got === r) begin
				if (r === e + 16'h0001) e = r;
				chk(r, e);
			end
		end
		chk(16'(e > 16'h1234), 16'h0001);
		$display("test double read done");
		tally_and_finish;
	end
endmodule
bind rcp_config rcp_config_props #(.SECOND_CYCLES(SECOND_CYCLES), .RIPPLE_CYCLES(RIPPLE_CYCLES))
	i_rcp_config_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .clock_module_on(clock_module_on), .clock_pin_output_on(clock_pin_output_on),
	.clock_pin_out(clock_pin_out), .rollover_ripple_flag(rollover_ripple_flag),
	.second_half_flag(second_half_flag));
